// [hdl/bridge_cfg_pkg.sv]
// Purpose: Shared constants and carriers for the configuration base block
// Assumes: Offsets are byte addresses inside configuration space
// Notes:   Both register ports and the window decoder use these names

package bridge_cfg_pkg;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFFSET_BASE_PRIMARY = 8'h10;
	localparam logic [7:0] OFFSET_BASE_SECONDARY = 8'h14;
	localparam logic [7:0] OFFSET_LATENCY_GRANT_INTERRUPT = 8'h3C;

	// ------------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------------
	localparam int BASE_LSB = 12;
	localparam int BASE_MSB = 31;
	localparam int BASE_WIDTH = 20;
	localparam int RESERVED_MSB = 11;
	localparam int RESERVED_LSB = 1;
	localparam int SPACE_BIT = 0;
	localparam int LANE_BITS = 8;
	localparam int BYTE_LANES = 4;
	localparam int FIRST_BASE_LANE = 1;
	localparam int INT_LINE_LANE = 0;
	localparam int WINDOW_COUNT = 2;
	localparam int WINDOW_PRIMARY = 0;
	localparam int WINDOW_SECONDARY = 1;

	// ------------------------------------------------------------------
	// Values and resets
	// ------------------------------------------------------------------
	localparam logic SPACE_MEMORY = 1'h0;
	localparam logic SPACE_IO = 1'h1;
	localparam logic [7:0] MAX_LATENCY_VALUE = 8'h00;
	localparam logic [7:0] MIN_GRANT_VALUE = 8'h03;
	localparam logic [7:0] INTERRUPT_PIN_VALUE = 8'h01;
	localparam logic [7:0] INTERRUPT_LINE_RESET = 8'h00;
	localparam logic [19:0] BASE_RESET = 20'h00000;
	localparam logic [3:0] ALL_LANES = 4'hF;
	localparam logic [31:0] READ_ZERO = 32'h00000000;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic write;
		logic [7:0] offset;
		logic [3:0] byte_enable;
		logic [31:0] write_data;
	} reg_request_t;

	typedef struct packed {
		logic valid;
		logic is_io;
		logic [31:0] address;
	} target_access_t;

	typedef enum logic [1:0] {
		SERVE_IDLE = 2'b00,
		SERVE_CONFIG = 2'b01,
		SERVE_VME = 2'b10
	} serve_state_t;

endpackage : bridge_cfg_pkg

// [hdl/window_match.sv]
// Purpose: Decodes one register window against a target access
// Assumes: Access fields are synchronous to i_clock
// Notes:   Hit is registered, one cycle after the access is presented

`timescale 1ns/1ps
`default_nettype none

module window_match
	import bridge_cfg_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// Window setup
	input wire logic [19:0] i_base,
	input wire logic i_space,
	input wire logic i_enabled,
	// Access
	input wire target_access_t i_access,
	// Result
	output logic o_hit
);

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	// No placement limit in either space: any aligned base decodes
	wire base_equal = i_access.address[BASE_MSB:BASE_LSB] == i_base;
	wire space_equal = i_access.is_io == i_space;
	wire next_hit = i_access.valid && i_enabled && space_equal && base_equal;

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
			o_hit <= 1'b0;
		else
			o_hit <= next_hit;
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_resetn);

	property p_closed_window;
		!i_enabled |=> !o_hit;
	endproperty
	a_closed_window: assert property (p_closed_window)
		else $error("window hit before its base was written");

	property p_memory_full_range;
		i_access.valid && i_enabled && !i_access.is_io &&
			i_space == SPACE_MEMORY && base_equal |=> o_hit;
	endproperty
	a_memory_full_range: assert property (p_memory_full_range)
		else $error("memory window missed an aligned access");

endmodule : window_match

`default_nettype wire

// [hdl/pci_config_base_regs.sv]
// Purpose: Configuration base registers and the latency/interrupt register
// Assumes: Config and VME register requests are held until acknowledged
// Notes:   Config port wins when both ports request in the same cycle

`timescale 1ns/1ps
`default_nettype none

// Contract
// - Base field 31:12 writable, resets zero
// - Strap low: primary I/O, secondary memory
// - Strap high: primary memory, secondary I/O
// - Secondary space bit inverts primary space bit
// - Space bit read-only, writes ignored
// - Memory window accepts any aligned base
// - No window access before base written
// - Enabling write via config or VME
// - Maximum latency byte reads zero
// - Minimum grant byte reads three
// - Interrupt pin byte reads one
// - Interrupt line byte is plain storage
module pci_config_base_regs
	import bridge_cfg_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// Power-up strap
	input wire logic i_power_up_addr_strap,
	// Configuration port
	input wire logic i_config_valid,
	input wire reg_request_t i_config_request,
	output logic o_config_ack,
	// VME register port
	input wire logic i_vme_valid,
	input wire reg_request_t i_vme_request,
	output logic o_vme_ack,
	// Shared read data
	output logic [31:0] o_read_data,
	// Window decode, space flag and interrupt line
	input wire target_access_t i_target_access,
	output logic [1:0] o_window_hit,
	output logic [1:0] o_window_enabled,
	output logic o_primary_is_io,
	output logic [7:0] o_interrupt_line
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	serve_state_t serve;
	serve_state_t next_serve;
	logic strap_done;
	logic primary_space;
	logic [19:0] window_base [WINDOW_COUNT];
	logic window_enabled [WINDOW_COUNT];
	logic [1:0] window_space;
	wire [1:0] window_hit;
	logic [7:0] interrupt_line;

	// ------------------------------------------------------------------
	// Port arbitration
	// ------------------------------------------------------------------
	// A port is not retaken in its own ack cycle, so a held request
	// is served once; requests wait until the strap has been caught
	wire take_config = strap_done && i_config_valid && serve != SERVE_CONFIG;
	wire take_vme = strap_done && i_vme_valid && !take_config &&
		serve != SERVE_VME;
	wire take_any = take_config || take_vme;

	always_comb
	begin
		next_serve = SERVE_IDLE;
		if (take_config)
			next_serve = SERVE_CONFIG;
		else if (take_vme)
			next_serve = SERVE_VME;
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
			serve <= SERVE_IDLE;
		else
			serve <= next_serve;
	end

	// ------------------------------------------------------------------
	// Selected request
	// ------------------------------------------------------------------
	wire reg_request_t selected = take_config ? i_config_request :
		i_vme_request;
	wire selected_write = selected.write;
	wire [31:0] selected_data = selected.write_data;
	wire [3:0] selected_lanes = selected.byte_enable;
	wire hit_primary = selected.offset == OFFSET_BASE_PRIMARY;
	wire hit_secondary = selected.offset == OFFSET_BASE_SECONDARY;
	wire hit_misc = selected.offset == OFFSET_LATENCY_GRANT_INTERRUPT;
	wire take_read = take_any && !selected_write;
	wire take_write = take_any && selected_write;
	wire [1:0] write_base = {take_write && hit_secondary,
		take_write && hit_primary};
	wire write_line = take_write && hit_misc &&
		selected_lanes[INT_LINE_LANE];

	// ------------------------------------------------------------------
	// Byte lane merge for a base field
	// ------------------------------------------------------------------
	function automatic logic [19:0] merge_base(
		input logic [19:0] old_base,
		input logic [31:0] data,
		input logic [3:0] lanes
	);
		logic [31:0] full;
		full = {old_base, READ_ZERO[BASE_LSB-1:0]};
		for (int lane = FIRST_BASE_LANE; lane < BYTE_LANES; lane++)
		begin
			if (lanes[lane])
				full[lane*LANE_BITS +: LANE_BITS] =
					data[lane*LANE_BITS +: LANE_BITS];
		end
		return full[BASE_MSB:BASE_LSB];
	endfunction : merge_base

	// ------------------------------------------------------------------
	// Strap capture
	// ------------------------------------------------------------------
	// Caught on the first edge after reset release, never under reset
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
			strap_done <= 1'b0;
		else
			strap_done <= 1'b1;
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
			primary_space <= SPACE_MEMORY;
		else if (!strap_done)
			primary_space <= !i_power_up_addr_strap;
	end

	// Space bits follow the strap only; bus writes never reach them
	assign window_space = {!primary_space, primary_space};

	// ------------------------------------------------------------------
	// Base registers and window decoders
	// ------------------------------------------------------------------
	for (genvar w = 0; w < WINDOW_COUNT; w++)
	begin : g_window
		always_ff @(posedge i_clock or negedge i_resetn)
		begin
			if (!i_resetn)
				window_base[w] <= BASE_RESET;
			else if (write_base[w])
				window_base[w] <= merge_base(window_base[w],
					selected_data, selected_lanes);
		end

		// Any write opens the window, even with no lanes enabled
		always_ff @(posedge i_clock or negedge i_resetn)
		begin
			if (!i_resetn)
				window_enabled[w] <= 1'b0;
			else if (write_base[w])
				window_enabled[w] <= 1'b1;
		end

		window_match u_match (
			.i_clock(i_clock),
			.i_resetn(i_resetn),
			.i_base(window_base[w]),
			.i_space(window_space[w]),
			.i_enabled(window_enabled[w]),
			.i_access(i_target_access),
			.o_hit(window_hit[w])
		);
	end

	assign o_window_hit = window_hit;

	// ------------------------------------------------------------------
	// Interrupt line storage
	// ------------------------------------------------------------------
	// Plain storage for software; only read back through the read mux and driven out on o_interrupt_line
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
			interrupt_line <= INTERRUPT_LINE_RESET;
		else if (write_line)
			interrupt_line <= selected_data[LANE_BITS-1:0];
	end

	// ------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------
	wire [RESERVED_MSB:RESERVED_LSB] reserved_zero = '0;
	wire [31:0] primary_word = {window_base[WINDOW_PRIMARY], reserved_zero,
		window_space[WINDOW_PRIMARY]};
	wire [31:0] secondary_word = {window_base[WINDOW_SECONDARY],
		reserved_zero, window_space[WINDOW_SECONDARY]};
	wire [31:0] misc_word = {MAX_LATENCY_VALUE, MIN_GRANT_VALUE,
		INTERRUPT_PIN_VALUE, interrupt_line};
	wire [31:0] read_value = hit_primary ? primary_word :
		hit_secondary ? secondary_word :
		hit_misc ? misc_word : READ_ZERO;

	// ------------------------------------------------------------------
	// Answers
	// ------------------------------------------------------------------
	// Writes return zero data; unmapped offsets read zero and still ack
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
			o_read_data <= READ_ZERO;
		else if (take_any)
			o_read_data <= selected_write ? READ_ZERO : read_value;
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_config_ack <= 1'b0;
			o_vme_ack <= 1'b0;
		end
		else
		begin
			o_config_ack <= take_config;
			o_vme_ack <= take_vme;
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_window_enabled <= 2'h0;
			o_primary_is_io <= SPACE_MEMORY;
			o_interrupt_line <= INTERRUPT_LINE_RESET;
		end
		else
		begin
			o_window_enabled <= {window_enabled[WINDOW_SECONDARY],
				window_enabled[WINDOW_PRIMARY]};
			o_primary_is_io <= primary_space;
			o_interrupt_line <= interrupt_line;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_resetn);

	sequence s_read_of(logic hit);
		take_read && hit;
	endsequence

	sequence s_full_write_of(logic hit);
		take_write && hit && selected_lanes == ALL_LANES;
	endsequence

	property p_strap_low;
		$rose(strap_done) && !$past(i_power_up_addr_strap) |->
			primary_space == SPACE_IO;
	endproperty
	a_strap_low: assert property (p_strap_low)
		else $error("strap low did not select I/O for primary");

	property p_strap_high;
		$rose(strap_done) && $past(i_power_up_addr_strap) |->
			primary_space == SPACE_MEMORY;
	endproperty
	a_strap_high: assert property (p_strap_high)
		else $error("strap high did not select memory for primary");

	property p_space_fixed;
		strap_done |=> $stable(primary_space) [*8];
	endproperty
	a_space_fixed: assert property (p_space_fixed)
		else $error("space bit changed after strap capture");

	property p_secondary_inverse;
		s_read_of(hit_secondary) |=> o_read_data[SPACE_BIT] != primary_space;
	endproperty
	a_secondary_inverse: assert property (p_secondary_inverse)
		else $error("secondary space bit is not the inverse");

	property p_base_write;
		s_full_write_of(hit_primary) |=>
			window_base[WINDOW_PRIMARY] ==
			$past(selected_data[BASE_MSB:BASE_LSB]);
	endproperty
	a_base_write: assert property (p_base_write)
		else $error("primary base field did not take the write");

	property p_reserved_zero;
		s_read_of(hit_primary || hit_secondary) |=>
			o_read_data[RESERVED_MSB:RESERVED_LSB] == '0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved base bits read nonzero");

	property p_max_latency;
		s_read_of(hit_misc) |=> o_read_data[31:24] == MAX_LATENCY_VALUE;
	endproperty
	a_max_latency: assert property (p_max_latency)
		else $error("maximum latency byte wrong");

	property p_min_grant;
		s_read_of(hit_misc) |=> o_read_data[23:16] == MIN_GRANT_VALUE;
	endproperty
	a_min_grant: assert property (p_min_grant)
		else $error("minimum grant byte wrong");

	property p_interrupt_pin;
		s_read_of(hit_misc) |=> o_read_data[15:8] == INTERRUPT_PIN_VALUE;
	endproperty
	a_interrupt_pin: assert property (p_interrupt_pin)
		else $error("interrupt pin byte wrong");

	property p_interrupt_line;
		write_line |=> ##1
			o_interrupt_line == $past(selected_data[LANE_BITS-1:0], 2);
	endproperty
	a_interrupt_line: assert property (p_interrupt_line)
		else $error("interrupt line byte did not take the write");

	property p_vme_opens_window;
		take_vme && selected_write && hit_primary |=>
			window_enabled[WINDOW_PRIMARY] ##1 o_window_enabled[WINDOW_PRIMARY];
	endproperty
	a_vme_opens_window: assert property (p_vme_opens_window)
		else $error("VME write did not open the primary window");

	property p_closed_until_write;
		!window_enabled[WINDOW_SECONDARY] |=> !o_window_hit[WINDOW_SECONDARY];
	endproperty
	a_closed_until_write: assert property (p_closed_until_write)
		else $error("secondary window hit before it was written");

endmodule : pci_config_base_regs

`default_nettype wire

// [bench/pci_host_model.sv]
// Purpose: PCI host that issues configuration reads and writes
// Assumes: Requests launch 1 ns after a rising edge of i_clock
// Notes:   Idle request write data shows the inverse of the last word sent

`timescale 1ns/1ps
`default_nettype none

module pci_host_model
	import bridge_cfg_pkg::*;
(
	// Clock
	input wire logic i_clock,
	// Device answer
	input wire logic i_ack,
	input wire logic [31:0] i_read_data,
	// Request
	output logic o_config_valid,
	output reg_request_t o_config_request
);
	// ------------------------------------------------------------
	// Transfer
	// ------------------------------------------------------------
	initial
	begin
		o_config_valid = 1'b0;
		o_config_request = '0;
	end

	// Held whole until ack is sampled, so the word is never torn
	task automatic xfer(input logic w, input logic [7:0] off,
		input logic [3:0] be, input logic [31:0] d,
		output logic [31:0] rd, output logic ok);
		int n;
		ok = 1'b0;
		@(posedge i_clock);
		#1;
		o_config_valid = 1'b1;
		o_config_request = '{w, off, be, d};
		for (n = 0; n < 20 && !ok; n++)
		begin
			@(posedge i_clock);
			ok = (i_ack === 1'b1);
		end
		rd = i_read_data;
		#1;
		o_config_valid = 1'b0;
		o_config_request.write_data = ~d;
	endtask : xfer
endmodule : pci_host_model

`default_nettype wire

// [bench/tb_pci_config_base_regs.sv]
// Purpose: Self-checking bench for the configuration base registers
// Assumes: Fixed seed, inputs driven 1 ns after the rising edge
// Notes:   Expected words are built from the field layout alone

`timescale 1ns/1ps
`default_nettype none

module tb_pci_config_base_regs;
	import bridge_cfg_pkg::*;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic i_clock = 1'b0;
	logic i_resetn = 1'b0;
	logic strap = 1'b0;
	logic vme_valid = 1'b0;
	reg_request_t vme_req = '0;
	target_access_t acc = '0;
	logic cfg_valid, cfg_ack, vme_ack, is_io;
	reg_request_t cfg_req;
	logic [31:0] rdata, r;
	logic [1:0] hit, enabled;
	logic [7:0] line, il;
	logic [19:0] b0, b1;
	int error_cnt = 0;
	int n_checks = 0;

	always #2 i_clock = ~i_clock;

	pci_config_base_regs uut (.i_clock(i_clock), .i_resetn(i_resetn),
		.i_power_up_addr_strap(strap), .i_config_valid(cfg_valid),
		.i_config_request(cfg_req), .o_config_ack(cfg_ack),
		.i_vme_valid(vme_valid), .i_vme_request(vme_req),
		.o_vme_ack(vme_ack), .o_read_data(rdata),
		.i_target_access(acc), .o_window_hit(hit),
		.o_window_enabled(enabled), .o_primary_is_io(is_io),
		.o_interrupt_line(line));

	pci_host_model host (.i_clock(i_clock), .i_ack(cfg_ack),
		.i_read_data(rdata), .o_config_valid(cfg_valid),
		.o_config_request(cfg_req));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			error_cnt++;
		end
	endtask : check

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	// One register access on either port; a lost ack ends the run
	task automatic rw(input bit vme, input logic w, input logic [7:0] off,
		input logic [3:0] be, input logic [31:0] d, output logic [31:0] rd);
		logic ok;
		int n;
		ok = 1'b0;
		if (!vme)
			host.xfer(w, off, be, d, rd, ok);
		else
		begin
			@(posedge i_clock);
			#1;
			vme_valid = 1'b1;
			vme_req = '{w, off, be, d};
			for (n = 0; n < 20 && !ok; n++)
			begin
				@(posedge i_clock);
				ok = (vme_ack === 1'b1);
			end
			rd = rdata;
			#1;
			vme_valid = 1'b0;
			vme_req.write_data = ~d;
		end
		if (ok !== 1'b1)
		begin
			error_cnt++;
			summarize();
		end
	endtask : rw

	task automatic probe(input logic io, input logic [31:0] a,
		input logic [1:0] exp);
		@(posedge i_clock);
		#1;
		acc = '{1'b1, io, a};
		@(posedge i_clock);
		#1;
		acc.valid = 1'b0;
		check("window hit", {30'h0, exp}, {30'h0, hit});
	endtask : probe

	task automatic do_reset(input logic s);
		#1;
		i_resetn = 1'b0;
		strap = s;
		repeat (6) @(posedge i_clock);
		#1;
		i_resetn = 1'b1;
		repeat (2) @(posedge i_clock);
	endtask : do_reset

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial
	begin
		void'($urandom(71));
		do_reset(1'b0);
		rw(0, 0, OFFSET_BASE_PRIMARY, ALL_LANES, '0, r);
		check("primary reset", 32'h00000001, r);
		rw(1, 0, OFFSET_BASE_SECONDARY, ALL_LANES, '0, r);
		check("secondary reset", 32'h00000000, r);
		rw(0, 0, OFFSET_LATENCY_GRANT_INTERRUPT, ALL_LANES, '0, r);
		check("misc reset", 32'h00030100, r);
		check("io flag", 32'h1, {31'h0, is_io});
		check("enabled", 32'h0, {30'h0, enabled});
		probe(1'b1, 32'h00000000, 2'b00);
		probe(1'b0, 32'h00000000, 2'b00);
		$display("test reset view done");
		// Ports alternate so each base is written from both sides
		for (int k = 0; k < 4; k++)
		begin
			b0 = 20'($urandom);
			b1 = (k == 0) ? 20'hFFFFF : 20'($urandom);
			rw(k[0], 1, OFFSET_BASE_PRIMARY, ALL_LANES, {b0, 12'hFFE}, r);
			check("write echo", 32'h0, r);
			rw(~k[0], 1, OFFSET_BASE_SECONDARY, ALL_LANES, {b1, 12'hFFF}, r);
			rw(k[0], 0, OFFSET_BASE_PRIMARY, ALL_LANES, '0, r);
			check("primary", {b0, 11'h0, 1'b1}, r);
			rw(~k[0], 0, OFFSET_BASE_SECONDARY, ALL_LANES, '0, r);
			check("secondary", {b1, 12'h000}, r);
			check("enabled", 32'h3, {30'h0, enabled});
			probe(1'b1, {b0, 12'($urandom)}, 2'b01);
			probe(1'b0, {b1, 12'($urandom)}, 2'b10);
			probe(1'b1, {~b0, 12'h000}, 2'b00);
		end
		$display("test bases done");
		il = 8'($urandom);
		rw(1, 1, OFFSET_LATENCY_GRANT_INTERRUPT, ALL_LANES, {24'hFFFFFF, il}, r);
		rw(0, 1, OFFSET_LATENCY_GRANT_INTERRUPT, 4'hE, 32'hFFFFFFFF, r);
		rw(0, 0, OFFSET_LATENCY_GRANT_INTERRUPT, ALL_LANES, '0, r);
		check("misc", {24'h000301, il}, r);
		check("line", {24'h0, il}, {24'h0, line});
		rw(1, 1, 8'h20, ALL_LANES, 32'hFFFFFFFF, r);
		rw(0, 0, 8'h20, ALL_LANES, '0, r);
		check("unmapped", 32'h0, r);
		$display("test misc done");
		do_reset(1'b1);
		rw(1, 0, OFFSET_BASE_PRIMARY, ALL_LANES, '0, r);
		check("primary strap high", 32'h00000000, r);
		rw(0, 0, OFFSET_BASE_SECONDARY, ALL_LANES, '0, r);
		check("secondary strap high", 32'h00000001, r);
		check("io flag strap high", 32'h0, {31'h0, is_io});
		rw(0, 0, OFFSET_LATENCY_GRANT_INTERRUPT, ALL_LANES, '0, r);
		check("misc after reset", 32'h00030100, r);
		check("enabled", 32'h0, {30'h0, enabled});
		probe(1'b0, 32'h00000000, 2'b00);
		rw(0, 1, OFFSET_BASE_PRIMARY, 4'h0, 32'h12345000, r);
		probe(1'b0, 32'h00000ABC, 2'b01);
		$display("test strap high done");
		summarize();
	end
endmodule : tb_pci_config_base_regs

`default_nettype wire
